// file: design/hbgc_port.sv
// Host bus arbitration port: prioritised requests, grant chains, data cycles
`include "hbgc_regs.svh"

// ****************************************************************
// Operation
// [RULE_01] Processor answers a non-processor request with its grant when bus idle.
// [RULE_02] Non-processor grant passes in to out, kept when this port requested.
// [RULE_03] Data and register words move over a 16-bit two-way data path.
// [RULE_04] Exactly one of the four level request lines 4..7 is raised. The code raises at most one of the five request lines, and none while idle.
// [RULE_05] Processor grants a level only for its request, after the instruction.
// [RULE_06] Each level grant passes in to out unless this port requested it.
// [RULE_07] Bus initialise clears the port and withdraws any pending request.
// [RULE_08] Slave answers master sync with slave sync; master raises master sync.
// [RULE_09] Request held until matching grant then dropped; grant out is combinational.
// ****************************************************************

module hbgc_port #(
    parameter int SETUP_CYC = `HBGC_MSYNC_SETUP_CYC
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic bus_initialise_n,
    input wire logic dma_grant_chain_in,
    output logic dma_grant_chain_out,
    output logic dma_request,
    input wire logic grant_in_level_seven,
    input wire logic grant_in_level_six,
    input wire logic grant_in_level_five,
    input wire logic grant_in_level_four,
    output logic grant_out_level_seven,
    output logic grant_out_level_six,
    output logic grant_out_level_five,
    output logic grant_out_level_four,
    output logic bus_request_level_seven,
    output logic bus_request_level_six,
    output logic bus_request_level_five,
    output logic bus_request_level_four,
    input wire logic [`HBGC_DATA_W-1:0] host_data_lines_n_in,
    output logic [`HBGC_DATA_W-1:0] host_data_lines_n_out,
    output logic host_data_lines_n_oe,
    input wire logic master_sync_n_in,
    output logic master_sync_n_out,
    output logic master_sync_n_oe,
    input wire logic slave_sync_n_in,
    output logic slave_sync_n_out,
    output logic slave_sync_n_oe,
    input wire logic user_req_valid,
    input hbgc_pkg::hbgc_req_t user_req,
    output logic user_req_ready,
    output logic bus_owned,
    input wire logic user_release,
    input wire logic slave_select,
    input wire logic slave_write,
    input wire logic [`HBGC_DATA_W-1:0] slave_rdata,
    output logic [`HBGC_DATA_W-1:0] slave_wdata,
    output logic slave_wr_strobe,
    input wire logic mst_start,
    input hbgc_pkg::hbgc_xfer_t mst_cmd,
    output logic mst_ready,
    output logic [`HBGC_DATA_W-1:0] mst_rdata,
    output logic mst_done
);

    // ************************************************************
    // Reset and chain mapping
    // ************************************************************

    logic hold_reset;
    logic [`HBGC_CHAINS-1:0] chain_in;
    logic [`HBGC_CHAINS-1:0] chain_out;
    logic [`HBGC_CHAINS-1:0] chain_sel;
    logic [`HBGC_CHAINS-1:0] chain_block;
    logic [`HBGC_CHAINS-1:0] req_lines;
    logic grant_hit;
    logic msync_drive;
    logic ssync_drive;
    hbgc_pkg::hbgc_arb_state_t arb_reg, arb_next;
    hbgc_pkg::hbgc_req_t req_reg, req_next;

    // Bus initialise acts as a second synchronous reset
    assign hold_reset = rst || !bus_initialise_n; // RULE_07

    // Bit 4 is the non-processor chain, bits 3..0 are levels 7..4
    assign chain_in = {dma_grant_chain_in, grant_in_level_seven,
        grant_in_level_six, grant_in_level_five, grant_in_level_four};

    // One-hot chain of the held request
    always_comb
    begin
        chain_sel = '0;
        if (req_reg.dma)
        begin
            chain_sel[`HBGC_DMA_CHAIN] = 1'b1;
        end
        else
        begin
            chain_sel[req_reg.level] = 1'b1; // RULE_04
        end
    end

    // ************************************************************
    // Grant chains
    // ************************************************************

    // Pass-through kept combinational so the chain adds no clock delay
    for (genvar g = 0; g < `HBGC_CHAINS; g++)
    begin : g_chain
        assign chain_block[g] = chain_sel[g]
            && (arb_reg != hbgc_pkg::HBGC_ARB_IDLE); // RULE_02 RULE_06
        assign chain_out[g] = chain_in[g] && !chain_block[g]; // RULE_09
        assign req_lines[g] = chain_sel[g]
            && (arb_reg == hbgc_pkg::HBGC_ARB_WAIT); // RULE_09
    end

    assign dma_grant_chain_out = chain_out[`HBGC_DMA_CHAIN];
    assign grant_out_level_seven = chain_out[3];
    assign grant_out_level_six = chain_out[2];
    assign grant_out_level_five = chain_out[1];
    assign grant_out_level_four = chain_out[0];
    assign dma_request = req_lines[`HBGC_DMA_CHAIN];
    assign bus_request_level_seven = req_lines[3];
    assign bus_request_level_six = req_lines[2];
    assign bus_request_level_five = req_lines[1];
    assign bus_request_level_four = req_lines[0];

    // ************************************************************
    // Arbitration state
    // ************************************************************

    // Only the grant on the chain we asked on counts
    assign grant_hit = |(chain_in & chain_sel);

    // Next request and ownership
    always_comb
    begin
        arb_next = arb_reg;
        req_next = req_reg;
        case (arb_reg)
            hbgc_pkg::HBGC_ARB_IDLE:
            begin
                if (user_req_valid)
                begin
                    req_next = user_req;
                    arb_next = hbgc_pkg::HBGC_ARB_WAIT;
                end
            end
            hbgc_pkg::HBGC_ARB_WAIT:
            begin
                // Request stays up until its own grant arrives
                if (grant_hit)
                begin
                    arb_next = hbgc_pkg::HBGC_ARB_OWN; // RULE_09
                end
            end
            hbgc_pkg::HBGC_ARB_OWN:
            begin
                if (user_release)
                begin
                    arb_next = hbgc_pkg::HBGC_ARB_IDLE;
                end
            end
            default:
            begin
                arb_next = hbgc_pkg::HBGC_ARB_IDLE;
            end
        endcase
    end

    // Arbitration registers, cleared by reset or bus initialise
    always_ff @(posedge mclk)
    begin
        if (hold_reset)
        begin
            arb_reg <= hbgc_pkg::HBGC_ARB_IDLE; // RULE_07
            req_reg <= '0;
        end
        else
        begin
            arb_reg <= arb_next;
            req_reg <= req_next;
        end
    end

    assign user_req_ready = arb_reg == hbgc_pkg::HBGC_ARB_IDLE;
    assign bus_owned = arb_reg == hbgc_pkg::HBGC_ARB_OWN;

    // ************************************************************
    // Data path and sync lines
    // ************************************************************

    hbgc_cycle #(
        .SETUP_CYC(SETUP_CYC)
    ) u_cycle (
        .mclk(mclk),
        .hold_reset(hold_reset),
        .msync_in(!master_sync_n_in),
        .ssync_in(!slave_sync_n_in),
        .slave_select(slave_select),
        .slave_write(slave_write),
        .data_in_n(host_data_lines_n_in),
        .slave_rdata(slave_rdata),
        .bus_owned(bus_owned),
        .mst_start(mst_start),
        .mst_cmd(mst_cmd),
        .msync_drive(msync_drive),
        .ssync_drive(ssync_drive),
        .data_oe(host_data_lines_n_oe),
        .data_out_n(host_data_lines_n_out),
        .slave_wdata(slave_wdata),
        .slave_wr_strobe(slave_wr_strobe),
        .mst_ready(mst_ready),
        .mst_rdata(mst_rdata),
        .mst_done(mst_done)
    );

    // Open-drain sync lines only ever pull low
    assign master_sync_n_out = 1'b0;
    assign master_sync_n_oe = msync_drive;
    assign slave_sync_n_out = 1'b0;
    assign slave_sync_n_oe = ssync_drive;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking port_cb @(posedge mclk); endclocking
    default disable iff (hold_reset);

    sequence s_waiting;
        arb_reg == hbgc_pkg::HBGC_ARB_WAIT;
    endsequence

    one_request_a: assert property ($onehot0(req_lines)) // RULE_04
        else $error("more than one request line raised");
    idle_pass_a: assert property (arb_reg == hbgc_pkg::HBGC_ARB_IDLE
        |-> chain_out == chain_in) // RULE_06
        else $error("grant not passed on while idle");
    dma_keep_a: assert property (s_waiting ##0 dma_request
        && dma_grant_chain_in |-> !dma_grant_chain_out ##1 bus_owned) // RULE_02
        else $error("non-processor grant not kept");
    req_held_a: assert property (s_waiting ##0 !grant_hit
        |=> $stable(req_lines) && |req_lines) // RULE_09
        else $error("request dropped before its grant");
    req_drop_a: assert property (s_waiting ##0 grant_hit
        |=> req_lines == '0 && bus_owned) // RULE_09
        else $error("request not dropped after grant");
    init_clear_a: assert property (@(posedge mclk) disable iff (rst)
        !bus_initialise_n |=> req_lines == '0 && !bus_owned) // RULE_07
        else $error("initialise did not clear the port");

endmodule // hbgc_port

// file: design/hbgc_regs.svh
// Timing counts, widths and chain positions of the host bus grant chain port
`ifndef HBGC_REGS_SVH
`define HBGC_REGS_SVH

// Host data path width in bits
`define HBGC_DATA_W 16
// Number of prioritised request levels, lowest level number
`define HBGC_LEVELS 4
`define HBGC_LOWEST_LEVEL 4
// Grant chains: four priority levels plus the non-processor chain
`define HBGC_CHAINS 5
`define HBGC_DMA_CHAIN 4
// Clock cycles data is driven before master sync is raised
`define HBGC_MSYNC_SETUP_CYC 1
// Width of the setup counter
`define HBGC_SETUP_CNT_W 4

`endif

// file: design/hbgc_pkg.sv
// Types shared by the host bus grant chain port modules
`include "hbgc_regs.svh"

package hbgc_pkg;

    // Arbitration state of the port
    typedef enum logic [1:0] {
        HBGC_ARB_IDLE = 2'b00,
        HBGC_ARB_WAIT = 2'b01,
        HBGC_ARB_OWN  = 2'b10
    } hbgc_arb_state_t;

    // Data cycle state, slave answer or master transfer
    typedef enum logic [2:0] {
        HBGC_CYC_IDLE  = 3'b000,
        HBGC_CYC_SLAVE = 3'b001,
        HBGC_CYC_SETUP = 3'b010,
        HBGC_CYC_SYNC  = 3'b011,
        HBGC_CYC_END   = 3'b100
    } hbgc_cyc_state_t;

    // Bus request: non-processor, or level 4 + level (0..3)
    typedef struct packed {
        logic dma;
        logic [1:0] level;
    } hbgc_req_t;

    // Master transfer command
    typedef struct packed {
        logic write;
        logic [`HBGC_DATA_W-1:0] data;
    } hbgc_xfer_t;

endpackage

// file: design/hbgc_cycle.sv
// Data cycle engine: slave answers and master transfers on the host bus
`include "hbgc_regs.svh"

module hbgc_cycle #(
    parameter int SETUP_CYC = `HBGC_MSYNC_SETUP_CYC
)(
    input wire logic mclk,
    input wire logic hold_reset,
    input wire logic msync_in,
    input wire logic ssync_in,
    input wire logic slave_select,
    input wire logic slave_write,
    input wire logic [`HBGC_DATA_W-1:0] data_in_n,
    input wire logic [`HBGC_DATA_W-1:0] slave_rdata,
    input wire logic bus_owned,
    input wire logic mst_start,
    input hbgc_pkg::hbgc_xfer_t mst_cmd,
    output logic msync_drive,
    output logic ssync_drive,
    output logic data_oe,
    output logic [`HBGC_DATA_W-1:0] data_out_n,
    output logic [`HBGC_DATA_W-1:0] slave_wdata,
    output logic slave_wr_strobe,
    output logic mst_ready,
    output logic [`HBGC_DATA_W-1:0] mst_rdata,
    output logic mst_done
);

    // Counter must hold the setup count and never start at zero
    if (SETUP_CYC < 1 || SETUP_CYC >= (1 << `HBGC_SETUP_CNT_W))
    begin : g_bad_setup
        $error("hbgc_cycle: SETUP_CYC out of range");
    end

    hbgc_pkg::hbgc_cyc_state_t st_reg, st_next;
    logic [`HBGC_SETUP_CNT_W-1:0] cnt_reg, cnt_next;
    logic drive_reg, drive_next;
    logic [`HBGC_DATA_W-1:0] dout_reg, dout_next;
    logic [`HBGC_DATA_W-1:0] wdata_reg, wdata_next;
    logic [`HBGC_DATA_W-1:0] rdata_reg, rdata_next;
    logic wstb_reg, wstb_next;
    logic done_reg, done_next;
    logic slave_hit;

    // Being addressed wins over starting our own transfer
    assign slave_hit = msync_in && slave_select;

    // Next state of the cycle engine
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        drive_next = drive_reg;
        dout_next = dout_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        wstb_next = 1'b0;
        done_next = 1'b0;
        case (st_reg)
            hbgc_pkg::HBGC_CYC_IDLE:
            begin
                if (slave_hit)
                begin
                    st_next = hbgc_pkg::HBGC_CYC_SLAVE;
                    drive_next = !slave_write;
                    if (slave_write)
                    begin
                        wdata_next = ~data_in_n; // RULE_03
                        wstb_next = 1'b1;
                    end
                    else
                    begin
                        dout_next = ~slave_rdata; // RULE_03
                    end
                end
                else if (mst_start && bus_owned)
                begin
                    st_next = hbgc_pkg::HBGC_CYC_SETUP;
                    drive_next = mst_cmd.write;
                    dout_next = ~mst_cmd.data;
                    cnt_next = `HBGC_SETUP_CNT_W'(SETUP_CYC);
                end
            end
            hbgc_pkg::HBGC_CYC_SLAVE:
            begin
                // Hold slave sync until the master lets go
                if (!msync_in)
                begin
                    st_next = hbgc_pkg::HBGC_CYC_IDLE; // RULE_08
                end
            end
            hbgc_pkg::HBGC_CYC_SETUP:
            begin
                // Data settles on the bus before master sync
                if (cnt_reg == `HBGC_SETUP_CNT_W'(1))
                begin
                    st_next = hbgc_pkg::HBGC_CYC_SYNC;
                end
                else
                begin
                    cnt_next = cnt_reg - `HBGC_SETUP_CNT_W'(1);
                end
            end
            hbgc_pkg::HBGC_CYC_SYNC:
            begin
                if (ssync_in)
                begin
                    if (!drive_reg)
                    begin
                        rdata_next = ~data_in_n;
                    end
                    done_next = 1'b1;
                    st_next = hbgc_pkg::HBGC_CYC_END; // RULE_08
                end
            end
            hbgc_pkg::HBGC_CYC_END:
            begin
                if (!ssync_in)
                begin
                    st_next = hbgc_pkg::HBGC_CYC_IDLE;
                end
            end
            default:
            begin
                st_next = hbgc_pkg::HBGC_CYC_IDLE;
            end
        endcase
    end

    // Cycle engine registers
    always_ff @(posedge mclk)
    begin
        if (hold_reset)
        begin
            st_reg <= hbgc_pkg::HBGC_CYC_IDLE;
            cnt_reg <= '0;
            drive_reg <= 1'b0;
            dout_reg <= {`HBGC_DATA_W{1'b1}};
            wdata_reg <= '0;
            rdata_reg <= '0;
            wstb_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            drive_reg <= drive_next;
            dout_reg <= dout_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            wstb_reg <= wstb_next;
            done_reg <= done_next;
        end
    end

    // Outputs
    assign ssync_drive = st_reg == hbgc_pkg::HBGC_CYC_SLAVE; // RULE_08
    assign msync_drive = st_reg == hbgc_pkg::HBGC_CYC_SYNC; // RULE_08
    assign data_oe = drive_reg && (st_reg != hbgc_pkg::HBGC_CYC_IDLE)
        && (st_reg != hbgc_pkg::HBGC_CYC_END); // RULE_03
    assign data_out_n = dout_reg;
    assign slave_wdata = wdata_reg;
    assign slave_wr_strobe = wstb_reg;
    assign mst_rdata = rdata_reg;
    assign mst_done = done_reg;
    assign mst_ready = (st_reg == hbgc_pkg::HBGC_CYC_IDLE) && bus_owned
        && !slave_hit;

    default clocking cyc_cb @(posedge mclk); endclocking
    default disable iff (hold_reset);

    sequence s_slave_read;
        st_reg == hbgc_pkg::HBGC_CYC_IDLE && slave_hit && !slave_write;
    endsequence

    sequence s_slave_wr;
        st_reg == hbgc_pkg::HBGC_CYC_IDLE && slave_hit && slave_write;
    endsequence

    slave_answer_a: assert property (s_slave_read or s_slave_wr |=> ssync_drive) // RULE_08
        else $error("slave sync not raised after master sync");
    slave_hold_a: assert property (ssync_drive && msync_in |=> ssync_drive) // RULE_08
        else $error("slave sync dropped while master sync held");
    read_data_a: assert property (s_slave_read
        |=> data_oe && data_out_n == ~$past(slave_rdata)) // RULE_03
        else $error("slave read data not driven on all lines");
    write_data_a: assert property (s_slave_wr
        |=> slave_wr_strobe && slave_wdata == ~$past(data_in_n)) // RULE_03
        else $error("slave write data not captured");
    master_sync_a: assert property (mst_start && mst_ready
        |=> !msync_drive ##[0:15] msync_drive) // RULE_08
        else $error("master sync not raised after setup");

endmodule // hbgc_cycle

// file: testbench/hbgc_host_model.sv
// Host processor model acting as arbiter of the grant chains
// ****************************************************************
// Grant arbiter
// ****************************************************************
module hbgc_host_model
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] req,
    output logic [4:0] grant
);
    timeunit 1ns;
    timeprecision 100ps;

    // Grant only the chain that asks; one cycle of thought stands in
    // for the instruction in flight. The bus is never ours while granting
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            grant <= 5'h00;
        end
        else if (grant != 5'h00)
        begin
            grant <= grant & req;
        end
        else
        begin
            grant <= req;
        end
    end
endmodule // hbgc_host_model

// file: testbench/hbgc_port_bench.sv
// Self-checking bench of the host bus grant chain port
// ****************************************************************
// Bench top
// ****************************************************************
module hbgc_port_bench;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        hbgc_pkg::hbgc_req_t req;
        logic [4:0] lines;
    } hbgc_row_t;

    logic mclk, rst, bus_initialise_n, dma_grant_chain_in, dma_grant_chain_out;
    logic dma_request, grant_in_level_seven, grant_in_level_six;
    logic grant_in_level_five, grant_in_level_four, grant_out_level_seven;
    logic grant_out_level_six, grant_out_level_five, grant_out_level_four;
    logic bus_request_level_seven, bus_request_level_six;
    logic bus_request_level_five, bus_request_level_four;
    logic [15:0] host_data_lines_n_in, host_data_lines_n_out;
    logic host_data_lines_n_oe, master_sync_n_in, master_sync_n_out;
    logic master_sync_n_oe, slave_sync_n_in, slave_sync_n_out, slave_sync_n_oe;
    logic user_req_valid, user_req_ready, bus_owned, user_release;
    logic slave_select, slave_write, slave_wr_strobe, mst_start, mst_ready;
    logic mst_done;
    logic [15:0] slave_rdata, slave_wdata, mst_rdata, bench_data;
    hbgc_pkg::hbgc_req_t user_req;
    hbgc_pkg::hbgc_xfer_t mst_cmd;
    logic [4:0] req_v, gout_v, model_grant, bench_grant;
    logic bench_msync, bench_ssync, hold_grant;
    int bad_count, tests_run, cycles;
    hbgc_row_t rows [5];

    // Chain vectors, non-processor chain on top
    assign req_v = {dma_request, bus_request_level_seven, bus_request_level_six,
        bus_request_level_five, bus_request_level_four};
    assign gout_v = {dma_grant_chain_out, grant_out_level_seven,
        grant_out_level_six, grant_out_level_five, grant_out_level_four};
    assign {dma_grant_chain_in, grant_in_level_seven, grant_in_level_six,
        grant_in_level_five, grant_in_level_four} = model_grant | bench_grant;
    // Open-drain lines: wired-AND, released lines float high
    assign host_data_lines_n_in = host_data_lines_n_oe ?
        (host_data_lines_n_out & bench_data) : bench_data;
    assign master_sync_n_in = ~(master_sync_n_oe | bench_msync);
    assign slave_sync_n_in = ~(slave_sync_n_oe | bench_ssync);

    hbgc_port #(.SETUP_CYC(1)) DUT (.mclk, .rst, .bus_initialise_n,
        .dma_grant_chain_in, .dma_grant_chain_out, .dma_request,
        .grant_in_level_seven, .grant_in_level_six, .grant_in_level_five,
        .grant_in_level_four, .grant_out_level_seven, .grant_out_level_six,
        .grant_out_level_five, .grant_out_level_four, .bus_request_level_seven,
        .bus_request_level_six, .bus_request_level_five,
        .bus_request_level_four, .host_data_lines_n_in, .host_data_lines_n_out,
        .host_data_lines_n_oe, .master_sync_n_in, .master_sync_n_out,
        .master_sync_n_oe, .slave_sync_n_in, .slave_sync_n_out,
        .slave_sync_n_oe, .user_req_valid, .user_req, .user_req_ready,
        .bus_owned, .user_release, .slave_select, .slave_write, .slave_rdata,
        .slave_wdata, .slave_wr_strobe, .mst_start, .mst_cmd, .mst_ready,
        .mst_rdata, .mst_done);

    hbgc_host_model HOST (.mclk(mclk),
        .rst(rst | hold_grant | ~bus_initialise_n), .req(req_v),
        .grant(model_grant));

    // Clock, 100 ns period
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return bus_owned;
            1: return slave_sync_n_oe;
            2: return slave_wr_strobe;
            3: return master_sync_n_oe;
            4: return mst_done;
            default: return ~slave_sync_n_oe;
        endcase
    endfunction

    // Bounded wait, returns one step after the edge that shows the signal
    task automatic wait_sig(input int k);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        while (sig(k) !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(sig(k), 1'b1);
    endtask

    task automatic request(input hbgc_pkg::hbgc_req_t r);
        @(posedge mclk);
        user_req_valid <= 1'b1;
        user_req <= r;
        @(posedge mclk);
        user_req_valid <= 1'b0;
    endtask

    task automatic release_bus();
        @(posedge mclk);
        user_release <= 1'b1;
        @(posedge mclk);
        user_release <= 1'b0;
        #1;
        check(user_req_ready, 1'b1);
    endtask

    // One master word; read data comes from the bench acting as slave
    task automatic master_word(input logic wr, input logic [15:0] d);
        @(posedge mclk);
        mst_cmd <= {wr, d};
        mst_start <= 1'b1;
        bench_data <= wr ? 16'hffff : ~d;
        @(posedge mclk);
        mst_start <= 1'b0;
        wait_sig(3);
        if (wr)
        begin
            check(host_data_lines_n_out, ~d);
            check(host_data_lines_n_oe, 1'b1);
        end
        @(posedge mclk);
        bench_ssync <= 1'b1;
        wait_sig(4);
        if (!wr)
        begin
            check(mst_rdata, d);
        end
        @(posedge mclk);
        bench_ssync <= 1'b0;
        bench_data <= 16'hffff;
        repeat (3) @(posedge mclk);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst = 1'b1;
        bus_initialise_n = 1'b1;
        user_req_valid = 1'b0;
        user_req = 3'b000;
        user_release = 1'b0;
        slave_select = 1'b0;
        slave_write = 1'b0;
        slave_rdata = 16'h0000;
        mst_start = 1'b0;
        mst_cmd = 17'h00000;
        bench_grant = 5'h15;
        bench_data = 16'hffff;
        bench_msync = 1'b0;
        bench_ssync = 1'b0;
        hold_grant = 1'b1;
        rows = '{'{3'b100, 5'h10}, '{3'b011, 5'h08}, '{3'b010, 5'h04},
            '{3'b001, 5'h02}, '{3'b000, 5'h01}};
        repeat (15) @(posedge mclk);
        #1;
        // Reset state, foreign grants flow through
        check(req_v, 5'h00);
        check(gout_v, 5'h15);
        check(host_data_lines_n_out, 16'hffff);
        check({host_data_lines_n_oe, master_sync_n_oe, slave_sync_n_oe}, 3'h0);
        check(user_req_ready, 1'b1);
        // Sync lines only pull low; no master start before ownership
        check({master_sync_n_out, slave_sync_n_out, mst_ready}, 3'h0);
        // Release on the sixteenth edge, so reset spans sixteen cycles
        @(posedge mclk);
        rst <= 1'b0;
        // Every request code: one line, own chain's grant held low at its input, others pass
        foreach (rows[i])
        begin
            @(posedge mclk);
            bench_grant <= ~rows[i].lines;
            hold_grant <= 1'b1;
            request(rows[i].req);
            @(posedge mclk);
            #1;
            check(req_v, rows[i].lines);
            check(gout_v, 5'(~rows[i].lines));
            @(posedge mclk);
            bench_grant <= 5'h00;
            hold_grant <= 1'b0;
            wait_sig(0);
            check(req_v, 5'h00);
            release_bus();
        end
        // Initialise withdraws a pending request
        hold_grant <= 1'b1;
        request(3'b001);
        @(posedge mclk);
        bus_initialise_n <= 1'b0;
        @(posedge mclk);
        bus_initialise_n <= 1'b1;
        #1;
        check(req_v, 5'h00);
        check(user_req_ready, 1'b1);
        hold_grant <= 1'b0;
        // Slave read: data returned inverted on the bus lines
        @(posedge mclk);
        bench_msync <= 1'b1;
        slave_select <= 1'b1;
        slave_rdata <= 16'h1234;
        wait_sig(1);
        check(host_data_lines_n_out, 16'hedcb);
        check(host_data_lines_n_oe, 1'b1);
        @(posedge mclk);
        bench_msync <= 1'b0;
        slave_select <= 1'b0;
        wait_sig(5);
        check(host_data_lines_n_oe, 1'b0);
        // Slave write of a word placed by the host
        @(posedge mclk);
        bench_data <= 16'h4110;
        bench_msync <= 1'b1;
        slave_select <= 1'b1;
        slave_write <= 1'b1;
        wait_sig(2);
        check(slave_wdata, 16'hbeef);
        @(posedge mclk);
        bench_msync <= 1'b0;
        slave_select <= 1'b0;
        slave_write <= 1'b0;
        bench_data <= 16'hffff;
        wait_sig(5);
        // Master words while owning the bus through the non-processor chain
        request(3'b100);
        wait_sig(0);
        check(mst_ready, 1'b1);
        master_word(1'b1, 16'h5a5a);
        master_word(1'b0, 16'hc3c3);
        release_bus();
        conclude();
    end
endmodule // hbgc_port_bench
